/* File: hdl/ism_ctrl.v */
// two instances of the two-wire controller control register with AXI4-Lite access
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ism_consts.vh"
// Summary of operation
// R1 - soft_reset bit 15 holds the controller in reset until cleared; release lines first
// R2 - smbus_alert_request bit 13 drives alert_pin; software sets/clears, hardware clears
// R3 - checksum_send bit 12 cleared after checksum sent, on START/STOP, or when disabled
// R4 - position 0: ack_enable and checksum_send apply to the current byte
// R5 - position 1: ack_enable and checksum_send apply to the next byte
// R6 - ack_enable bit 10 selects ACK or NACK; ack bits cleared when disabled
// R7 - stop request bit 9 makes STOP; set by timeout, cleared on STOP seen
// R8 - start request bit 8 makes START; cleared on START seen or disabled
// R9 - stretch_disable bit 7 forbids slave clock stretching when set
// R10 - general_call_accept bit 6 makes the slave answer address 0x00
// R11 - checksum computed over bytes only while checksum_calc_enable bit 5 is set
// R12 - address_resolution_enable bit 4 turns on address resolution in SMBus mode
// R13 - smbus_role_select bit 3: 0 device role, 1 host role
// R14 - smbus_mode_select bit 1: 0 plain I2C, 1 SMBus
// R15 - peripheral_enable bit 0 turns the whole controller on or off
// R16 - 16- and 32-bit accesses; reserved bits 31:16, 14, 2 stay zero
// R17 - two identical instances at 0x4000 5400 and 0x4000 5800, register at offset 0
// R18 - checksum is CRC-8 x8+x2+x+1 over every byte including the address
// R19 - a hardware clear beats a software write to the same bit
module ism_ctrl (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [1:0] scl_in,
  input wire [1:0] sda_in,
  input wire [1:0] smb_timeout,
  input wire [1:0] checksum_sent,
  input wire [1:0] alert_done,
  input wire [1:0] rx_byte_done,
  input wire [1:0] byte_valid,
  input wire [15:0] byte_data,
  input wire [1:0] addr_valid,
  input wire [15:0] addr_byte,
  output wire [1:0] alert_pin_o,
  output wire [1:0] alert_pin_oe,
  output wire [1:0] engine_reset,
  output wire [1:0] start_gen,
  output wire [1:0] stop_gen,
  output wire [1:0] ack_level,
  output wire [1:0] checksum_byte,
  output wire [1:0] stretch_allow,
  output wire [1:0] gc_match,
  output wire [1:0] arp_active,
  output wire [1:0] smbus_host,
  output wire [1:0] smbus_mode,
  output wire [1:0] enabled,
  output wire [1:0] start_seen,
  output wire [1:0] stop_seen,
  output wire [15:0] checksum_value
);
  reg awready_q;
  reg wready_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg arready_q;
  reg rvalid_q;
  reg [1:0] rresp_q;
  reg [31:0] rdata_q;
  reg aw_have_q;
  reg w_have_q;
  reg [31:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire do_write;
  wire [31:0] ctl_flat;
  wire [1:0] wr_hit;
  wire [15:0] wr_mask;

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  assign do_write = aw_have_q && w_have_q && !bvalid_q;
  assign wr_hit[0] = do_write && ({awaddr_q[31:2], 2'b00} == (`ISM_BASE0 + `ISM_OFF_CTL)); // R17
  assign wr_hit[1] = do_write && ({awaddr_q[31:2], 2'b00} == (`ISM_BASE1 + `ISM_OFF_CTL)); // R17
  // byte lanes 0 and 1 only; reserved bits never store
  assign wr_mask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}} & `ISM_CTL_WMASK; // R16

  // write channel: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 32'h00000000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `ISM_RESP_OKAY;
    end else begin
      awready_q <= !aw_have_q && !(s_axi_awvalid && awready_q) && !bvalid_q;
      wready_q <= !w_have_q && !(s_axi_wvalid && wready_q) && !bvalid_q;
      if (s_axi_awvalid && awready_q) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wr_hit != 2'b00) ? `ISM_RESP_OKAY : `ISM_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read channel: one read outstanding
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= `ISM_RESP_OKAY;
      rdata_q <= 32'h00000000;
    end else begin
      arready_q <= !rvalid_q && !(s_axi_arvalid && arready_q);
      if (s_axi_arvalid && arready_q) begin
        rvalid_q <= 1'b1;
        rresp_q <= `ISM_RESP_OKAY;
        case ({s_axi_araddr[31:2], 2'b00})
          `ISM_BASE0 + `ISM_OFF_CTL: rdata_q <= {16'h0000, ctl_flat[15:0]}; // R16
          `ISM_BASE1 + `ISM_OFF_CTL: rdata_q <= {16'h0000, ctl_flat[31:16]}; // R16
          `ISM_BASE0 + `ISM_OFF_CRC: rdata_q <= {24'h000000, checksum_value[7:0]};
          `ISM_BASE1 + `ISM_OFF_CRC: rdata_q <= {24'h000000, checksum_value[15:8]};
          default: begin
            rdata_q <= 32'h00000000;
            rresp_q <= `ISM_RESP_SLVERR;
          end
        endcase
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : unit
      reg [15:0] ctl_q;
      reg [15:0] ctl_d;
      reg scl_m_q;
      reg scl_s_q;
      reg scl_p_q;
      reg sda_m_q;
      reg sda_s_q;
      reg sda_p_q;
      reg start_q;
      reg stop_q;
      reg ack_next_q;
      reg pec_next_q;
      reg ack_q;
      reg pecb_q;
      reg gc_q;
      reg cfg_rst_q;
      reg alert_oe_q;
      reg [6:0] cfg_q;
      wire start_det;
      wire stop_det;
      wire [7:0] crc;

      // START: data falls while clock high; STOP: data rises while clock high
      assign start_det = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
      assign stop_det = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;

      always @* begin
        ctl_d = ctl_q;
        if (wr_hit[gi]) begin
          ctl_d = (ctl_q & ~wr_mask) | (wdata_q[15:0] & wr_mask); // R16
        end
        // hardware clears placed after the write so they win
        if (alert_done[gi]) begin
          ctl_d[`ISM_B_ALERT] = 1'b0; // R2 R19
        end
        if (checksum_sent[gi] || start_det || stop_det || !ctl_d[`ISM_B_EN]) begin
          ctl_d[`ISM_B_PECTX] = 1'b0; // R3 R19
        end
        if (!ctl_d[`ISM_B_EN]) begin
          ctl_d[`ISM_B_POS] = 1'b0; // R6 R19
          ctl_d[`ISM_B_ACK] = 1'b0; // R6 R19
        end
        if (start_det || !ctl_d[`ISM_B_EN]) begin
          ctl_d[`ISM_B_START] = 1'b0; // R8 R19
        end
        if (stop_det) begin
          ctl_d[`ISM_B_STOP] = 1'b0; // R7 R19
        end
        if (smb_timeout[gi]) begin
          ctl_d[`ISM_B_STOP] = 1'b1; // R7
        end
      end

      always @(posedge aclk) begin
        if (!aresetn) begin
          ctl_q <= `ISM_CTL_RESET;
          scl_m_q <= 1'b1;
          scl_s_q <= 1'b1;
          scl_p_q <= 1'b1;
          sda_m_q <= 1'b1;
          sda_s_q <= 1'b1;
          sda_p_q <= 1'b1;
          start_q <= 1'b0;
          stop_q <= 1'b0;
          ack_next_q <= 1'b0;
          pec_next_q <= 1'b0;
          ack_q <= 1'b0;
          pecb_q <= 1'b0;
          gc_q <= 1'b0;
          cfg_rst_q <= 1'b0;
          alert_oe_q <= 1'b0;
          cfg_q <= 7'h00;
        end else begin
          ctl_q <= ctl_d;
          scl_m_q <= scl_in[gi];
          scl_s_q <= scl_m_q;
          scl_p_q <= scl_s_q;
          sda_m_q <= sda_in[gi];
          sda_s_q <= sda_m_q;
          sda_p_q <= sda_s_q;
          start_q <= start_det;
          stop_q <= stop_det;
          cfg_rst_q <= ctl_q[`ISM_B_SRST] || !ctl_q[`ISM_B_EN]; // R1 R15
          alert_oe_q <= ctl_q[`ISM_B_ALERT] && ctl_q[`ISM_B_EN]; // R2
          // deferred settings become active at the byte boundary
          if (rx_byte_done[gi]) begin
            ack_next_q <= ctl_q[`ISM_B_ACK]; // R5
            pec_next_q <= ctl_q[`ISM_B_PECTX]; // R5
          end
          if (!ctl_q[`ISM_B_EN]) begin
            ack_next_q <= 1'b0; // R6
            pec_next_q <= 1'b0;
          end
          if (ctl_q[`ISM_B_POS]) begin
            ack_q <= ack_next_q; // R5
            pecb_q <= pec_next_q; // R5
          end else begin
            ack_q <= ctl_q[`ISM_B_ACK]; // R4 R6
            pecb_q <= ctl_q[`ISM_B_PECTX]; // R4
          end
          gc_q <= addr_valid[gi] && ctl_q[`ISM_B_GC] && ctl_q[`ISM_B_EN] &&
                  (addr_byte[gi*8+7 -: 7] == `ISM_GC_ADDR); // R10
          cfg_q[0] <= ctl_q[`ISM_B_START] && ctl_q[`ISM_B_EN]; // R8
          cfg_q[1] <= ctl_q[`ISM_B_STOP] && ctl_q[`ISM_B_EN]; // R7
          cfg_q[2] <= !ctl_q[`ISM_B_SS]; // R9
          cfg_q[3] <= ctl_q[`ISM_B_SMB] && ctl_q[`ISM_B_ARP]; // R12
          cfg_q[4] <= ctl_q[`ISM_B_ROLE]; // R13
          cfg_q[5] <= ctl_q[`ISM_B_SMB]; // R14
          cfg_q[6] <= ctl_q[`ISM_B_EN]; // R15
        end
      end

      ism_crc8 u_crc (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(start_det || ctl_q[`ISM_B_SRST] || !ctl_q[`ISM_B_EN]), // R1 R15
        .enable(ctl_q[`ISM_B_CHECKSUM_CALC_ENABLE]), // R11
        .byte_valid(byte_valid[gi]), // R18
        .byte_data(byte_data[gi*8+7 -: 8]),
        .crc_q(crc)
      );

      assign ctl_flat[gi*16+15 -: 16] = ctl_q;
      assign checksum_value[gi*8+7 -: 8] = crc;
      assign alert_pin_o[gi] = 1'b0;
      assign alert_pin_oe[gi] = alert_oe_q;
      assign engine_reset[gi] = cfg_rst_q;
      assign start_gen[gi] = cfg_q[0];
      assign stop_gen[gi] = cfg_q[1];
      assign stretch_allow[gi] = cfg_q[2];
      assign arp_active[gi] = cfg_q[3];
      assign smbus_host[gi] = cfg_q[4];
      assign smbus_mode[gi] = cfg_q[5];
      assign enabled[gi] = cfg_q[6];
      assign ack_level[gi] = ack_q;
      assign checksum_byte[gi] = pecb_q;
      assign gc_match[gi] = gc_q;
      assign start_seen[gi] = start_q;
      assign stop_seen[gi] = stop_q;
    end
  endgenerate
endmodule // ism_ctrl
`default_nettype wire

/* File: hdl/ism_consts.vh */
// constants for the two-wire controller control register block
`ifndef ISM_CONSTS_VH
`define ISM_CONSTS_VH
`define ISM_BASE0 32'h40005400
`define ISM_BASE1 32'h40005800
`define ISM_OFF_CTL 32'h00000000
`define ISM_OFF_CRC 32'h00000020
`define ISM_CTL_RESET 16'h0000
`define ISM_CTL_WMASK 16'hBFFB
`define ISM_B_EN 0
`define ISM_B_SMB 1
`define ISM_B_ROLE 3
`define ISM_B_ARP 4
`define ISM_B_CHECKSUM_CALC_ENABLE 5
`define ISM_B_GC 6
`define ISM_B_SS 7
`define ISM_B_START 8
`define ISM_B_STOP 9
`define ISM_B_ACK 10
`define ISM_B_POS 11
`define ISM_B_PECTX 12
`define ISM_B_ALERT 13
`define ISM_B_SRST 15
`define ISM_CRC_POLY 8'h07
`define ISM_CRC_INIT 8'h00
`define ISM_GC_ADDR 7'h00
`define ISM_RESP_OKAY 2'h0
`define ISM_RESP_SLVERR 2'h2
`endif

/* File: hdl/ism_crc8.v */
// byte-wide packet checksum accumulator
`timescale 1ns/1ps
`default_nettype none
`include "ism_consts.vh"
module ism_crc8 (
  input wire aclk,
  input wire aresetn,
  input wire clear,
  input wire enable,
  input wire byte_valid,
  input wire [7:0] byte_data,
  output reg [7:0] crc_q
);
  reg [7:0] crc_d;
  reg [7:0] c;
  integer k;

  // msb first, one byte per cycle
  always @* begin
    c = crc_q ^ byte_data;
    for (k = 0; k < 8; k = k + 1) begin
      if (c[7]) begin
        c = {c[6:0], 1'b0} ^ `ISM_CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    crc_d = crc_q;
    if (clear) begin
      crc_d = `ISM_CRC_INIT;
    end else if (enable && byte_valid) begin // R11 R18
      crc_d = c;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      crc_q <= `ISM_CRC_INIT;
    end else begin
      crc_q <= crc_d;
    end
  end
endmodule // ism_crc8
`default_nettype wire

/* File: verification/ism_ctrl_assertions.sv */
// assertion checker for the control register block
`timescale 1ns/1ps
`default_nettype none
module ism_ctrl_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] alert_pin_o,
  input wire logic [1:0] alert_pin_oe,
  input wire logic [1:0] start_gen,
  input wire logic [1:0] stop_gen,
  input wire logic [1:0] enabled,
  input wire logic [1:0] arp_active,
  input wire logic [1:0] smbus_mode,
  input wire logic [1:0] start_seen,
  input wire logic [1:0] stop_seen,
  input wire logic [1:0] smb_timeout,
  input wire logic [1:0] gc_match,
  input wire logic [1:0] addr_valid,
  input wire logic [15:0] addr_byte,
  input wire logic s_axi_rvalid,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_alert_out_low: assert property (alert_pin_oe[0] |-> enabled[0] && !alert_pin_o[0])
    else $error("alert driven while off");
  a_start_needs_en: assert property (start_gen[0] |-> enabled[0]) else $error("start while off");
  a_arp_needs_smb: assert property (arp_active[0] |-> smbus_mode[0]) else $error("arp in i2c mode");
  a_start_seen_clr: assert property (start_seen[0] |-> ##[1:2] !start_gen[0]) else $error("start kept");
  a_stop_seen_clr: assert property (stop_seen[0] && !smb_timeout[0] |-> ##[1:2] !stop_gen[0])
    else $error("stop kept");
  a_timeout_stop: assert property (smb_timeout[0] && enabled[0] |-> ##[1:3] stop_gen[0])
    else $error("no stop on timeout");
  a_gc_addr_zero: assert property (gc_match[0] |-> $past(addr_valid[0]) && $past(addr_byte[7:1]) == 7'h00)
    else $error("stray general call");
  a_err_rdata: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read data");
endmodule // ism_ctrl_chk
bind ism_ctrl ism_ctrl_chk u_chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .alert_pin_o(alert_pin_o),
  .alert_pin_oe(alert_pin_oe),
  .start_gen(start_gen),
  .stop_gen(stop_gen),
  .enabled(enabled),
  .arp_active(arp_active),
  .smbus_mode(smbus_mode),
  .start_seen(start_seen),
  .stop_seen(stop_seen),
  .smb_timeout(smb_timeout),
  .gc_match(gc_match),
  .addr_valid(addr_valid),
  .addr_byte(addr_byte),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rdata(s_axi_rdata)
);
`default_nettype wire

/* File: verification/ism_line_model.sv */
// two-wire bus line model making start and stop conditions
`timescale 1ns/1ps
`default_nettype none
module ism_line_model (
  output var logic [1:0] scl,
  output var logic [1:0] sda
);
  // lines idle released at the pull-up level
  initial begin
    scl = 2'h3;
    sda = 2'h3;
  end
  // pin changes kept off the clock edges
  task automatic cond_start(input int i);
    #10;
    #200 sda[i] = 1'b0;
    #200 scl[i] = 1'b0;
    #200;
  endtask
  task automatic cond_stop(input int i);
    #10;
    sda[i] = 1'b0;
    #200 scl[i] = 1'b1;
    #200 sda[i] = 1'b1;
    #200;
  endtask
endmodule // ism_line_model
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench for the control register block
`timescale 1ns/1ps
`default_nettype none
`include "ism_consts.vh"
module tb_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, rs;
  logic [3:0] s_axi_wstrb;
  logic [1:0] smb_timeout, checksum_sent, alert_done, rx_byte_done, byte_valid, addr_valid;
  logic [15:0] byte_data, addr_byte, d;
  logic [7:0] c;
  logic [33:0] q [$];
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, scl_in, sda_in, alert_pin_o, alert_pin_oe, engine_reset;
  wire [1:0] start_gen, stop_gen, ack_level, checksum_byte, stretch_allow, gc_match, arp_active;
  wire [1:0] smbus_host, smbus_mode, enabled, start_seen, stop_seen;
  wire [31:0] s_axi_rdata;
  wire [15:0] checksum_value;
  int bad_count, n_checks, n, i, gcn, g0;
  localparam logic [31:0] B0 = `ISM_BASE0;
  localparam logic [31:0] B1 = `ISM_BASE1;
  localparam logic [47:0] TV = {16'h2001, 16'h1001, 16'h0001};
  localparam logic [47:0] TE = {16'h0001, 16'h0001, 16'h0201};
  localparam logic [23:0] GA = {8'h28, 8'h00, 8'h00};
  ism_ctrl i_dut (.*);
  ism_line_model u_line (.scl(scl_in), .sda(sda_in));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction
  function automatic logic [7:0] crc_step(input logic [7:0] x, input logic [7:0] b);
    x = x ^ b;
    for (int k = 0; k < 8; k++) x = x[7] ? ((x << 1) ^ 8'h07) : (x << 1);
    return x;
  endfunction
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic axw(input logic [31:0] a, input logic [15:0] v, input logic [3:0] st, input logic [33:0] e);
    logic ad;
    logic wd;
    q.push_back(e);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, v};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    ad = 1'b0;
    wd = 1'b0;
    while (!(ad && wd)) begin
      @(posedge aclk);
      ad = ad | s_axi_awready;
      wd = wd | s_axi_wready;
      if (ad) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [31:0] a, input logic [33:0] e);
    q.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  // one-cycle strobe on one engine input of instance 0
  task automatic pulse(input int k);
    @(posedge aclk);
    case (k)
      0: smb_timeout <= 2'h1;
      1: checksum_sent <= 2'h1;
      2: alert_done <= 2'h1;
      3: rx_byte_done <= 2'h1;
      4: byte_valid <= 2'h1;
      default: addr_valid <= 2'h1;
    endcase
    @(posedge aclk);
    {smb_timeout, checksum_sent, alert_done, rx_byte_done, byte_valid, addr_valid} <= 12'h000;
    repeat (3) @(posedge aclk);
  endtask
  always @(posedge aclk) begin
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
      chk(s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata}, q.pop_front());
  end
  always @(posedge aclk) if (gc_match[0]) gcn++;
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  initial begin
    #500000;
    bad_count++;
    close_out();
  end
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = 100'h0;
    {smb_timeout, checksum_sent, alert_done, rx_byte_done, byte_valid, addr_valid, byte_data, addr_byte} = 44'h0;
    rs = 32'h000151FF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    axr(B0, 34'h0);
    axr(B1, 34'h0);
    axr(B0 + 32'h10, {2'h2, 32'h0});
    axw(B1 + 32'h10, 16'h0001, 4'hF, {2'h2, 32'h0});
    axw(B0 + `ISM_OFF_CRC, 16'h0001, 4'hF, {2'h2, 32'h0});
    $display("end of map test");
    for (n = 0; n < 8; n++) begin
      rs = xs(rs);
      i = n % 2;
      d = (rs[15:0] & 16'hB7FB) | 16'h0001;
      axw(i ? B1 : B0, d, 4'h3, 34'h0);
      axr(i ? B1 : B0, {18'h0, d});
      chk({engine_reset[i], start_gen[i], stop_gen[i], ack_level[i], checksum_byte[i], stretch_allow[i]},
        {d[15], d[8], d[9], d[10], d[12], !d[7]});
      chk({arp_active[i], smbus_host[i], smbus_mode[i], enabled[i], alert_pin_oe[i]},
        {d[1] & d[4], d[3], d[1], 1'b1, d[13]});
    end
    $display("end of field test");
    axw(B0, 16'h1F00, 4'h3, 34'h0);
    axr(B0, 34'h0200);
    chk({enabled[0], engine_reset[0]}, 2'h1);
    axw(B0, 16'hFFFB, 4'h1, 34'h0);
    axr(B0, 34'h02FB);
    for (n = 0; n < 3; n++) begin
      axw(B0, TV[16 * n +: 16], 4'h3, 34'h0);
      pulse(n);
      axr(B0, {18'h0, TE[16 * n +: 16]});
    end
    axw(B0, 16'h1301, 4'h3, 34'h0);
    u_line.cond_start(0);
    repeat (8) @(posedge aclk);
    axr(B0, 34'h0201);
    axw(B0, 16'h1201, 4'h3, 34'h0);
    u_line.cond_stop(0);
    repeat (8) @(posedge aclk);
    axr(B0, 34'h0001);
    $display("end of hardware clear test");
    axw(B0, 16'h0021, 4'h3, 34'h0);
    c = 8'h00;
    for (n = 0; n < 4; n++) begin
      rs = xs(rs);
      byte_data <= {8'h00, rs[7:0]};
      if (n < 3) c = crc_step(c, rs[7:0]);
      if (n == 3) axw(B0, 16'h0001, 4'h3, 34'h0);
      pulse(4);
    end
    axr(B0 + `ISM_OFF_CRC, {26'h0, c});
    chk(checksum_value[7:0], c);
    for (n = 0; n < 3; n++) begin
      axw(B0, n == 1 ? 16'h0001 : 16'h0041, 4'h3, 34'h0);
      addr_byte <= {8'h00, GA[8 * n +: 8]};
      g0 = gcn;
      pulse(5);
      @(negedge aclk);
      chk(gcn - g0, n == 0);
    end
    axw(B0, 16'h0C01, 4'h3, 34'h0);
    pulse(3);
    axw(B0, 16'h0801, 4'h3, 34'h0);
    @(posedge aclk);
    chk(ack_level[0], 1'b1);
    pulse(3);
    chk(ack_level[0], 1'b0);
    $display("end of checksum and address test");
    close_out();
  end
endmodule // tb_top
`default_nettype wire
